// ### gtr_regs.svh
// gtr_regs.svh: register offsets, field positions and reset values of the timer block
// assumes a 16-bit register port addressed by the printed byte offsets
`ifndef GTR_REGS_SVH
`define GTR_REGS_SVH

// register offsets
`define GTR_A_T1_CNT   16'h0100
`define GTR_A_T1_PER   16'h0102
`define GTR_A_T1_CON   16'h0104
`define GTR_A_T2_CNT   16'h0106
`define GTR_A_HOLD     16'h0108
`define GTR_A_T3_CNT   16'h010A
`define GTR_A_T2_PER   16'h010C
`define GTR_A_T3_PER   16'h010E
`define GTR_A_T2_CON   16'h0110
`define GTR_A_T3_CON   16'h0112
`define GTR_A_FLAGS    16'h0120
`define GTR_A_IRQ_EN   16'h0122
`define GTR_A_OSC      16'h0124

// control field positions
`define GTR_B_ON       15
`define GTR_B_IDLE     13
`define GTR_B_GATE     6
`define GTR_B_PS_HI    5
`define GTR_B_PS_LO    4
`define GTR_B_T32      3
`define GTR_B_SYNC     2
`define GTR_B_CS       1
`define GTR_B_LPOSC    1

// flag and enable bit positions
`define GTR_B_F_T1     0
`define GTR_B_F_LOWER  1
`define GTR_B_F_UPPER  2

// implemented control bits
`define GTR_M_T1_CON   16'hA076
`define GTR_M_T2_CON   16'hA07A
`define GTR_M_T3_CON   16'hA072

// reset values
`define GTR_R_PER      16'hFFFF
`define GTR_R_ZERO     16'h0000

// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define GTR_P_DIV1     8'h00
`define GTR_P_DIV8     8'h07
`define GTR_P_DIV64    8'h3F
`define GTR_P_DIV256   8'hFF

`endif

// ### gtr_pkg.sv
// gtr_pkg.sv: state type of the timer block
// assumes gtr_regs.svh for field layout; nothing here is imported
package gtr_pkg;

	typedef struct packed {
		logic [3:0]  sync1;
		logic [3:0]  sync2;
		logic [3:0]  sync3;
		logic [3:0]  filt;
		logic [15:0] t1_cnt;
		logic [15:0] t1_per;
		logic [15:0] t1_con;
		logic [7:0]  t1_pre;
		logic [15:0] t2_cnt;
		logic [15:0] t2_per;
		logic [15:0] t2_con;
		logic [7:0]  t2_pre;
		logic [15:0] t3_cnt;
		logic [15:0] t3_per;
		logic [15:0] t3_con;
		logic [7:0]  t3_pre;
		logic [15:0] hold;
		logic        lposc;
		logic [2:0]  flags;
		logic [2:0]  irq_en;
		logic [15:0] rdata;
		logic        adc;
		logic        wake;
	} gtr_state_t;

endpackage : gtr_pkg

// ### gtr_timers.sv
// gtr_timers.sv: first timer with real-time clock, and the lower/upper timer pair
// assumes clk_in at 10 MHz as instruction cycle, pins asynchronous to it
//
// Contract
// - first timer match with period sets its flag; flag held until software clears
// - gated first timer also sets its flag on gate falling edge
// - rtc: on, external, not gated counts osc rising edges to period then zero
// - low-power osc enable blocks normal modes, carry-out makes wake-up event
// - rtc keeps counting during sleep
// - pair works as two 16-bit timers or one 32-bit timer/sync counter
// - lower timer holds low word, upper timer high word
// - 32-bit mode uses lower control, clock and gate only
// - 32-bit interrupts use upper flag and upper enable
// - each 16-bit timer chooses instruction clock or synchronous external clock
// - lower timer prescaler output synchronised; upper likewise, but without gated mode or 32-bit select
// - 32-bit timer counts each cycle to combined period, then zero
// - reading lower count captures upper count into holding register
// - holding written first, then lower write loads upper from holding
// - 32-bit sync counter counts external rising edges to combined period
// - sync counter stops in idle when idle stop set, else keeps counting
// - gated mode counts cycles while lower gate high; upper ignores gate
// - gate falling edge ends accumulation without clearing count
// - upper timer emits adc trigger on 32-bit or upper 16-bit match
// - prescaler divides by 1, 8, 64 or 256
// - prescaler cleared by count or control write only when on, and by reset always
//
// The address-and-strobe port was decided locally.
`include "gtr_regs.svh"

module gtr_timers (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// register port
	input  wire logic [15:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output wire logic [15:0] rdata_out,
	// pins and oscillator
	input  wire logic        t1_clk_pin_in,
	input  wire logic        lower_timer_gate_pin_in,
	input  wire logic        upper_clk_pin_in,
	input  wire logic        lp_osc_in,
	// cpu power state
	input  wire logic        cpu_idle_in,
	input  wire logic        cpu_sleep_in,
	// events
	output wire logic        first_timer_irq_out,
	output wire logic        lower_timer_irq_out,
	output wire logic        upper_timer_irq_out,
	output wire logic        adc_trigger_out,
	output wire logic        wakeup_out
);

	gtr_pkg::gtr_state_t r_reg;
	gtr_pkg::gtr_state_t r_next;

	logic [3:0]  filt_now;
	logic [3:0]  rise;
	logic [3:0]  fall;
	logic        t1_ev;
	logic        t1_tick;
	logic        t2_ev;
	logic        t2_tick;
	logic        t3_ev;
	logic        t3_tick;
	logic        t32;
	logic        m1;
	logic        m2;
	logic        m3;
	logic        m32;
	logic        gfall1;
	logic        gfall2;
	logic        rtc_mode;

	function automatic logic pre_done(input logic [7:0] cnt, input logic [1:0] sel);
		logic [7:0] term;
		case (sel)
			2'h0:    term = `GTR_P_DIV1;
			2'h1:    term = `GTR_P_DIV8;
			2'h2:    term = `GTR_P_DIV64;
			default: term = `GTR_P_DIV256;
		endcase
		return cnt == term;
	endfunction : pre_done

	always_comb begin
		r_next = r_reg;
		// pin synchronisers; a change counts once stages two and three agree
		r_next.sync1 = {lp_osc_in, upper_clk_pin_in, lower_timer_gate_pin_in, t1_clk_pin_in};
		r_next.sync2 = r_reg.sync1;
		r_next.sync3 = r_reg.sync2;
		filt_now = (~(r_reg.sync2 ^ r_reg.sync3) & r_reg.sync3) | ((r_reg.sync2 ^ r_reg.sync3) & r_reg.filt);
		r_next.filt = filt_now;
		rise = filt_now & ~r_reg.filt;
		fall = ~filt_now & r_reg.filt;

		// first timer input event
		rtc_mode = r_reg.lposc;
		if (cpu_idle_in && r_reg.t1_con[`GTR_B_IDLE]) begin
			t1_ev = 1'b0;
		end else if (rtc_mode) begin
			t1_ev = r_reg.t1_con[`GTR_B_ON] && r_reg.t1_con[`GTR_B_CS] && !r_reg.t1_con[`GTR_B_GATE]
				&& rise[3];
		end else if (cpu_sleep_in && !(r_reg.t1_con[`GTR_B_CS] && !r_reg.t1_con[`GTR_B_SYNC])) begin
			t1_ev = 1'b0;
		end else if (r_reg.t1_con[`GTR_B_CS]) begin
			t1_ev = r_reg.t1_con[`GTR_B_ON] && rise[0];
		end else if (r_reg.t1_con[`GTR_B_GATE]) begin
			t1_ev = r_reg.t1_con[`GTR_B_ON] && filt_now[0];
		end else begin
			t1_ev = r_reg.t1_con[`GTR_B_ON];
		end
		t1_tick = t1_ev && pre_done(r_reg.t1_pre, r_reg.t1_con[`GTR_B_PS_HI:`GTR_B_PS_LO]);
		if (t1_ev) begin
			r_next.t1_pre = t1_tick ? 8'h00 : r_reg.t1_pre + 8'h01;
		end
		m1 = t1_tick && (r_reg.t1_cnt == r_reg.t1_per);
		if (t1_tick) begin
			r_next.t1_cnt = m1 ? `GTR_R_ZERO : r_reg.t1_cnt + 16'h0001;
		end
		gfall1 = r_reg.t1_con[`GTR_B_ON] && r_reg.t1_con[`GTR_B_GATE] && !r_reg.t1_con[`GTR_B_CS]
			&& !rtc_mode && fall[0];
		r_next.wake = m1 && rtc_mode;

		// lower timer, also the 32-bit source
		t32 = r_reg.t2_con[`GTR_B_T32];
		if (!r_reg.t2_con[`GTR_B_ON] || cpu_sleep_in || (cpu_idle_in && r_reg.t2_con[`GTR_B_IDLE])) begin
			t2_ev = 1'b0;
		end else if (r_reg.t2_con[`GTR_B_CS]) begin
			t2_ev = rise[1];
		end else if (r_reg.t2_con[`GTR_B_GATE]) begin
			t2_ev = filt_now[1];
		end else begin
			t2_ev = 1'b1;
		end
		// prescaler output is taken inside the clk_in domain, hence synchronised
		t2_tick = t2_ev && pre_done(r_reg.t2_pre, r_reg.t2_con[`GTR_B_PS_HI:`GTR_B_PS_LO]);
		if (t2_ev) begin
			r_next.t2_pre = t2_tick ? 8'h00 : r_reg.t2_pre + 8'h01;
		end
		gfall2 = r_reg.t2_con[`GTR_B_ON] && r_reg.t2_con[`GTR_B_GATE] && !r_reg.t2_con[`GTR_B_CS] && fall[1];

		// upper timer, idle in 32-bit mode; its gate bit is never used
		if (t32 || !r_reg.t3_con[`GTR_B_ON] || cpu_sleep_in || (cpu_idle_in && r_reg.t3_con[`GTR_B_IDLE])) begin
			t3_ev = 1'b0;
		end else if (r_reg.t3_con[`GTR_B_CS]) begin
			t3_ev = rise[2];
		end else begin
			t3_ev = 1'b1;
		end
		t3_tick = t3_ev && pre_done(r_reg.t3_pre, r_reg.t3_con[`GTR_B_PS_HI:`GTR_B_PS_LO]);
		if (t3_ev) begin
			r_next.t3_pre = t3_tick ? 8'h00 : r_reg.t3_pre + 8'h01;
		end

		m32 = t32 && t2_tick && ({r_reg.t3_cnt, r_reg.t2_cnt} == {r_reg.t3_per, r_reg.t2_per});
		m2 = !t32 && t2_tick && (r_reg.t2_cnt == r_reg.t2_per);
		m3 = t3_tick && (r_reg.t3_cnt == r_reg.t3_per);
		if (t32) begin
			if (t2_tick) begin
				{r_next.t3_cnt, r_next.t2_cnt} = m32 ? 32'h00000000
					: {r_reg.t3_cnt, r_reg.t2_cnt} + 32'h00000001;
			end
		end else begin
			if (t2_tick) begin
				r_next.t2_cnt = m2 ? `GTR_R_ZERO : r_reg.t2_cnt + 16'h0001;
			end
			if (t3_tick) begin
				r_next.t3_cnt = m3 ? `GTR_R_ZERO : r_reg.t3_cnt + 16'h0001;
			end
		end
		r_next.adc = m32 || m3;

		// register writes; counting is overridden by a write in the same cycle
		if (wr_in) begin
			if (addr_in == `GTR_A_T1_CNT) begin
				r_next.t1_cnt = wdata_in;
				if (r_reg.t1_con[`GTR_B_ON]) r_next.t1_pre = 8'h00;
			end else if (addr_in == `GTR_A_T1_PER) begin
				r_next.t1_per = wdata_in;
			end else if (addr_in == `GTR_A_T1_CON) begin
				r_next.t1_con = wdata_in & `GTR_M_T1_CON;
				if (r_reg.t1_con[`GTR_B_ON]) r_next.t1_pre = 8'h00;
			end else if (addr_in == `GTR_A_T2_CNT) begin
				r_next.t2_cnt = wdata_in;
				if (t32) r_next.t3_cnt = r_reg.hold;
				if (r_reg.t2_con[`GTR_B_ON]) r_next.t2_pre = 8'h00;
			end else if (addr_in == `GTR_A_HOLD) begin
				r_next.hold = wdata_in;
			end else if (addr_in == `GTR_A_T3_CNT) begin
				r_next.t3_cnt = wdata_in;
				if (r_reg.t3_con[`GTR_B_ON]) r_next.t3_pre = 8'h00;
			end else if (addr_in == `GTR_A_T2_PER) begin
				r_next.t2_per = wdata_in;
			end else if (addr_in == `GTR_A_T3_PER) begin
				r_next.t3_per = wdata_in;
			end else if (addr_in == `GTR_A_T2_CON) begin
				r_next.t2_con = wdata_in & `GTR_M_T2_CON;
				if (r_reg.t2_con[`GTR_B_ON]) r_next.t2_pre = 8'h00;
			end else if (addr_in == `GTR_A_T3_CON) begin
				r_next.t3_con = wdata_in & `GTR_M_T3_CON;
				if (r_reg.t3_con[`GTR_B_ON]) r_next.t3_pre = 8'h00;
			end else if (addr_in == `GTR_A_FLAGS) begin
				r_next.flags = wdata_in[2:0];
			end else if (addr_in == `GTR_A_IRQ_EN) begin
				r_next.irq_en = wdata_in[2:0];
			end else if (addr_in == `GTR_A_OSC) begin
				r_next.lposc = wdata_in[`GTR_B_LPOSC];
			end
		end

		// hardware set wins over a software clear
		r_next.flags[`GTR_B_F_T1] = r_next.flags[`GTR_B_F_T1] | m1 | gfall1;
		r_next.flags[`GTR_B_F_LOWER] = r_next.flags[`GTR_B_F_LOWER] | m2 | (gfall2 && !t32);
		r_next.flags[`GTR_B_F_UPPER] = r_next.flags[`GTR_B_F_UPPER] | m32 | m3 | (gfall2 && t32);

		// reads: data one cycle later, unmapped reads zero
		r_next.rdata = 16'h0000;
		if (rd_in) begin
			if (addr_in == `GTR_A_T1_CNT) begin
				r_next.rdata = r_reg.t1_cnt;
			end else if (addr_in == `GTR_A_T1_PER) begin
				r_next.rdata = r_reg.t1_per;
			end else if (addr_in == `GTR_A_T1_CON) begin
				r_next.rdata = r_reg.t1_con;
			end else if (addr_in == `GTR_A_T2_CNT) begin
				r_next.rdata = r_reg.t2_cnt;
				r_next.hold = r_reg.t3_cnt;
			end else if (addr_in == `GTR_A_HOLD) begin
				r_next.rdata = r_reg.hold;
			end else if (addr_in == `GTR_A_T3_CNT) begin
				r_next.rdata = r_reg.t3_cnt;
			end else if (addr_in == `GTR_A_T2_PER) begin
				r_next.rdata = r_reg.t2_per;
			end else if (addr_in == `GTR_A_T3_PER) begin
				r_next.rdata = r_reg.t3_per;
			end else if (addr_in == `GTR_A_T2_CON) begin
				r_next.rdata = r_reg.t2_con;
			end else if (addr_in == `GTR_A_T3_CON) begin
				r_next.rdata = r_reg.t3_con;
			end else if (addr_in == `GTR_A_FLAGS) begin
				r_next.rdata = {13'h0000, r_reg.flags};
			end else if (addr_in == `GTR_A_IRQ_EN) begin
				r_next.rdata = {13'h0000, r_reg.irq_en};
			end else if (addr_in == `GTR_A_OSC) begin
				r_next.rdata = {14'h0000, r_reg.lposc, 1'b0};
			end
		end

		if (rst_in) begin
			r_next = '0;
			r_next.t1_per = `GTR_R_PER;
			r_next.t2_per = `GTR_R_PER;
			r_next.t3_per = `GTR_R_PER;
		end
	end

	always_ff @(posedge clk_in) begin
		r_reg <= r_next;
	end

	assign rdata_out = r_reg.rdata;
	assign first_timer_irq_out = r_reg.flags[`GTR_B_F_T1] & r_reg.irq_en[`GTR_B_F_T1];
	assign lower_timer_irq_out = r_reg.flags[`GTR_B_F_LOWER] & r_reg.irq_en[`GTR_B_F_LOWER];
	assign upper_timer_irq_out = r_reg.flags[`GTR_B_F_UPPER] & r_reg.irq_en[`GTR_B_F_UPPER];
	assign adc_trigger_out = r_reg.adc;
	assign wakeup_out = r_reg.wake;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence hold_written;
		wr_in && addr_in == `GTR_A_HOLD;
	endsequence
	sequence lower_written_32;
		wr_in && addr_in == `GTR_A_T2_CNT && t32;
	endsequence

	chk_t1_match_flag: assert property (m1 && !wr_in |=> r_reg.t1_cnt == 16'h0000 && r_reg.flags[0])
		else $error("first timer match did not wrap and flag");
	chk_t1_gate_fall: assert property (gfall1 |=> r_reg.flags[0])
		else $error("gate falling edge did not flag first timer");
	chk_rtc_osc_only: assert property (r_reg.lposc && t1_ev |-> rise[3] && r_reg.t1_con[15])
		else $error("rtc counted without oscillator edge");
	chk_rtc_sleep_run: assert property (r_reg.lposc && cpu_sleep_in && !cpu_idle_in && r_reg.t1_con[15]
		&& r_reg.t1_con[1] && !r_reg.t1_con[6] && rise[3] |-> t1_ev)
		else $error("rtc stopped during sleep");
	chk_wake_carry: assert property (m1 |=> wakeup_out == $past(r_reg.lposc))
		else $error("wake-up event does not follow carry-out");
	chk_pair_wrap32: assert property (m32 && !wr_in |=> {r_reg.t3_cnt, r_reg.t2_cnt} == 32'h00000000
		&& r_reg.flags[2] && adc_trigger_out)
		else $error("32-bit match did not wrap, flag and trigger");
	chk_upper_adc: assert property (m3 |=> adc_trigger_out ##1 !adc_trigger_out || $past(m3 || m32))
		else $error("upper match did not give one trigger");
	chk_hold_capture: assert property (rd_in && addr_in == `GTR_A_T2_CNT |=> r_reg.hold == $past(r_reg.t3_cnt))
		else $error("lower read did not capture upper count");
	chk_hold_write: assert property (hold_written ##1 lower_written_32 |=>
		r_reg.t3_cnt == $past(r_reg.hold))
		else $error("lower write did not load upper from holding");
	chk_pair_idle: assert property (t32 && cpu_idle_in && r_reg.t2_con[13] && !wr_in |=> $stable(r_reg.t2_cnt)
		&& $stable(r_reg.t3_cnt))
		else $error("pair counted in idle with idle stop");
	chk_gate_keep: assert property (gfall2 && !t2_ev && !wr_in |=> r_reg.t2_cnt == $past(r_reg.t2_cnt))
		else $error("gate falling edge changed lower count");

endmodule : gtr_timers

// ### gtr_pins_model.sv
// gtr_pins_model.sv: far side of the timer block: low-power oscillator, gate level and external clock
// assumes the bench asks for each source by level; sources stand at 0 while not asked for
module gtr_pins_model #(
	parameter int OSC_HALF_NS = 15625,
	parameter int EXT_HALF_NS = 400
) (
	// requests from the bench
	input  wire logic osc_run_in,
	input  wire logic gate_req_in,
	input  wire logic ext_run_in,
	// pins toward the timer block
	output wire logic lp_osc_out,
	output wire logic lower_pin_out,
	output wire logic t1_pin_out,
	output wire logic upper_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic osc_reg;
	logic ext_reg;
	// 32 kHz oscillator, stops low when disabled
	initial begin
		osc_reg = 1'b0;
		forever #OSC_HALF_NS osc_reg = osc_run_in ? ~osc_reg : 1'b0;
	end
	// slow external clock, synchronous counting needs each level held for at least two clk_in cycles
	initial begin
		ext_reg = 1'b0;
		forever #EXT_HALF_NS ext_reg = ext_run_in ? ~ext_reg : 1'b0;
	end
	assign lp_osc_out    = osc_reg;
	assign lower_pin_out = gate_req_in | ext_reg;
	assign t1_pin_out    = gate_req_in | ext_reg;
	assign upper_pin_out = ext_reg;
endmodule : gtr_pins_model

// ### gtr_timers_test.sv
// gtr_timers_test.sv: self-checking bench of the timer block
// assumes gtr_timers and gtr_pins_model; register port driven on rising edges
`include "gtr_regs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end

module gtr_timers_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in, rst_in, wr_in, rd_in, cpu_idle_in, cpu_sleep_in;
	logic [15:0] addr_in, wdata_in, rdata_out, d, h, l;
	logic        lp_osc, low_pin, t1_pin, up_pin, osc_run, gate_req, ext_run;
	logic        irq1, irq2, irq3, adc, wake;
	logic [31:0] seed;
	int          fail_count, checks_done, n;
	logic [15:0] ra [11] = '{16'h0102, 16'h010C, 16'h010E, 16'h0100, 16'h0104, 16'h0106,
		16'h0110, 16'h0112, 16'h0120, 16'h0124, 16'h0200};

	gtr_timers u_gtr_timers (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .t1_clk_pin_in(t1_pin),
		.lower_timer_gate_pin_in(low_pin), .upper_clk_pin_in(up_pin), .lp_osc_in(lp_osc),
		.cpu_idle_in(cpu_idle_in), .cpu_sleep_in(cpu_sleep_in), .first_timer_irq_out(irq1),
		.lower_timer_irq_out(irq2), .upper_timer_irq_out(irq3), .adc_trigger_out(adc), .wakeup_out(wake));
	gtr_pins_model u_gtr_pins_model (.osc_run_in(osc_run), .gate_req_in(gate_req), .ext_run_in(ext_run),
		.lp_osc_out(lp_osc), .lower_pin_out(low_pin), .t1_pin_out(t1_pin), .upper_pin_out(up_pin));

	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : xs
	function automatic int presc_exp(int ps);
		return 512 >> ((ps == 0) ? 0 : (ps == 1) ? 3 : (ps == 2) ? 6 : 8);
	endfunction : presc_exp
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= v;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in   <= 1'b0;
		@(negedge clk_in);
		v = rdata_out;
	endtask : rd
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		repeat (12000) @(posedge clk_in);
		fail_count++;
		end_sim();
	end
	initial begin
		seed = 29;
		fail_count = 0;
		checks_done = 0;
		{rst_in, wr_in, rd_in, cpu_idle_in, cpu_sleep_in, osc_run, gate_req, ext_run} <= 8'h80;
		addr_in  <= 16'h0000;
		wdata_in <= 16'h0000;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		// reset values, then unmapped read
		for (int i = 0; i < 11; i++) begin
			rd(ra[i], d);
			`CHK("reset value", (i < 3) ? `GTR_R_PER : `GTR_R_ZERO, d)
		end
		for (int i = 0; i < 6; i++) begin
			h = xs();
			wr(ra[i % 3], h);
			rd(ra[i % 3], d);
			`CHK("period rw", h, d)
		end
		h = xs() & 16'h7FFF;
		wr(`GTR_A_T1_CON, h);
		rd(`GTR_A_T1_CON, d);
		`CHK("control bits", h & `GTR_M_T1_CON, d)
		// first timer match sets a sticky flag
		wr(`GTR_A_T1_CON, 16'h0000);
		wr(`GTR_A_T1_PER, 16'h0005);
		wr(`GTR_A_T1_CNT, 16'h0000);
		wr(`GTR_A_IRQ_EN, 16'h0007);
		wr(`GTR_A_T1_CON, 16'h8000);
		for (n = 0; n < 30 && irq1 !== 1'b1; n++) @(negedge clk_in);
		wr(`GTR_A_T1_CON, 16'h0000);
		repeat (10) @(posedge clk_in);
		@(negedge clk_in);
		`CHK("first irq", 1'b1, irq1)
		wr(`GTR_A_FLAGS, 16'h0000);
		@(negedge clk_in);
		`CHK("first irq cleared", 1'b0, irq1)
		// 32-bit match on upper flag with adc pulse
		wr(`GTR_A_T3_PER, 16'h0000);
		wr(`GTR_A_T2_PER, 16'h0002);
		wr(`GTR_A_T2_CON, 16'h8008);
		wr(`GTR_A_T3_CON, 16'h8000);
		for (n = 0; n < 20 && adc !== 1'b1; n++) @(negedge clk_in);
		`CHK("adc trigger", 1'b1, adc)
		`CHK("upper irq", 1'b1, irq3)
		`CHK("lower irq", 1'b0, irq2)
		@(negedge clk_in);
		`CHK("adc pulse", 1'b0, adc)
		// coherent 32-bit write, carry and read
		h = xs();
		wr(`GTR_A_T2_CON, 16'h0008);
		wr(`GTR_A_T3_CON, 16'h0000);
		wr(`GTR_A_T2_PER, 16'hFFFF);
		wr(`GTR_A_T3_PER, 16'hFFFF);
		wr(`GTR_A_HOLD, h);
		wr(`GTR_A_T2_CNT, 16'hFFFF);
		rd(`GTR_A_T3_CNT, d);
		`CHK("held word loaded", h, d)
		wr(`GTR_A_HOLD, 16'h0000);
		wr(`GTR_A_T2_CON, 16'h8008);
		repeat (4) @(posedge clk_in);
		wr(`GTR_A_T2_CON, 16'h0008);
		rd(`GTR_A_T2_CNT, l);
		`CHK("low word", 1'b1, l < 16'h0010)
		rd(`GTR_A_HOLD, d);
		`CHK("captured high word", h + 16'h0001, d)
		// gated accumulation on lower and first timer
		wr(`GTR_A_T2_CON, 16'h0000);
		wr(`GTR_A_T2_CNT, 16'h0000);
		wr(`GTR_A_T1_PER, 16'hFFFF);
		wr(`GTR_A_T1_CNT, 16'h0000);
		wr(`GTR_A_FLAGS, 16'h0000);
		wr(`GTR_A_T2_CON, 16'h8040);
		wr(`GTR_A_T1_CON, 16'h8040);
		@(posedge clk_in);
		gate_req <= 1'b1;
		repeat (30) @(posedge clk_in);
		gate_req <= 1'b0;
		repeat (10) @(posedge clk_in);
		rd(`GTR_A_T2_CNT, l);
		`CHK("gated count", 1'b1, l >= 16'd28 && l <= 16'd32)
		`CHK("gate end lower irq", 1'b1, irq2)
		`CHK("gate end first irq", 1'b1, irq1)
		repeat (10) @(posedge clk_in);
		rd(`GTR_A_T2_CNT, d);
		`CHK("count kept", l, d)
		wr(`GTR_A_T1_CON, 16'h0000);
		// 32-bit synchronous counter halted by idle
		wr(`GTR_A_T2_CNT, 16'h0000);
		wr(`GTR_A_T2_CON, 16'hA00A);
		@(posedge clk_in);
		cpu_idle_in <= 1'b1;
		ext_run     <= 1'b1;
		repeat (60) @(posedge clk_in);
		rd(`GTR_A_T2_CNT, d);
		`CHK("idle stopped", 16'h0000, d)
		cpu_idle_in <= 1'b0;
		repeat (60) @(posedge clk_in);
		rd(`GTR_A_T2_CNT, d);
		`CHK("sync count", 1'b1, d >= 16'd5 && d <= 16'd9)
		ext_run <= 1'b0;
		// prescaler ratios on the lower timer
		for (int ps = 0; ps < 4; ps++) begin
			wr(`GTR_A_T2_CON, 16'h0000);
			wr(`GTR_A_T2_CNT, 16'h0000);
			wr(`GTR_A_T2_CON, 16'h8000 | 16'(ps << 4));
			repeat (512) @(posedge clk_in);
			wr(`GTR_A_T2_CON, 16'h0000);
			rd(`GTR_A_T2_CNT, d);
			`CHK("prescale", 1'b1, int'(d) + 2 >= presc_exp(ps) && int'(d) <= presc_exp(ps) + 2)
		end
		// real-time clock from the oscillator through sleep
		wr(`GTR_A_FLAGS, 16'h0000);
		wr(`GTR_A_OSC, 16'h0002);
		wr(`GTR_A_T1_CNT, 16'h0000);
		wr(`GTR_A_T1_PER, 16'h0002);
		wr(`GTR_A_T1_CON, 16'h8000);
		repeat (20) @(posedge clk_in);
		rd(`GTR_A_T1_CNT, d);
		`CHK("normal mode blocked", 16'h0000, d)
		wr(`GTR_A_T1_CON, 16'h8002);
		@(posedge clk_in);
		cpu_sleep_in <= 1'b1;
		osc_run      <= 1'b1;
		for (n = 0; n < 1500 && wake !== 1'b1; n++) @(negedge clk_in);
		`CHK("wake event", 1'b1, wake)
		`CHK("rtc irq", 1'b1, irq1)
		rd(`GTR_A_T1_CNT, d);
		`CHK("rtc wrapped", 16'h0000, d)
		end_sim();
	end
endmodule : gtr_timers_test
